// ---- pkg/bfh_defs.vh ----
// bfh_defs.vh: constants of the buck fault and hiccup sequencer
// assumes inclusion by bare name from the rtl files; definitions only
`ifndef BFH_DEFS_VH
`define BFH_DEFS_VH

// register offsets on the 4-bit software port
`define BFH_ADDR_CTRL 4'h0
`define BFH_ADDR_STATUS 4'h1
`define BFH_ADDR_INT_STAT 4'h2
`define BFH_ADDR_INT_MASK 4'h3
`define BFH_ADDR_HICCUP_CNT 4'h4

// control register fields, control and mask reset values
`define BFH_CTRL_ENABLE 0
`define BFH_CTRL_SLAVE 1
`define BFH_CTRL_RESET 2'h0
`define BFH_MASK_RESET 7'h00

// event bit positions in interrupt status and mask registers
`define BFH_EV_AVG_OC 0
`define BFH_EV_CSH_OV 1
`define BFH_EV_THERMAL 2
`define BFH_EV_UNDERV 3
`define BFH_EV_FB_OV 4
`define BFH_EV_EXT_OV 5
`define BFH_EV_CYC_OC 6
`define BFH_EV_W 7

// synchronised input indices
`define BFH_IN_OCP_CYC 0
`define BFH_IN_OCP_NEG 1
`define BFH_IN_CURRENT_MONITOR_OUTPUT_OVER 2
`define BFH_IN_FB_BELOW 3
`define BFH_IN_FB_ABOVE 4
`define BFH_IN_CSH_OV 5
`define BFH_IN_EXT_OV 6
`define BFH_IN_THERM_HOT 7
`define BFH_IN_THERM_COOL 8
`define BFH_IN_SS_1V 9
`define BFH_IN_SS_50MV 10
`define BFH_IN_LIMIT_PROGRAM_INPUT_WIN 11
`define BFH_IN_HS_OFF 12
`define BFH_IN_LS_OFF 13
`define BFH_IN_PWM_HS 14
`define BFH_IN_CFG_DONE 15
`define BFH_IN_W 16

// timing counts in switching-clock cycles
`define BFH_HICCUP_CYCLES 16'h8000
`define BFH_QUAL_MORE_32 6'h21
`define BFH_QUAL_LEAST_32 6'h20

// sequencer states
`define BFH_ST_INIT 3'h0
`define BFH_ST_RUN 3'h1
`define BFH_ST_HICCUP 3'h2
`define BFH_ST_UV_WAIT 3'h3
`define BFH_ST_THERM 3'h4
`define BFH_ST_EXT_OV 3'h5

`endif

// ---- rtl/bfh_top.v ----
// bfh_top.v: fault handling, hiccup sequencing and gate interlock
// assumes comparator flags arrive asynchronously and are synchronised
// here; core_clk is the switching-oscillator clock; nrst is the
// enable / undervoltage-lockout shutdown path
//
// Function
// - after config, share current; slaves follow share
// - gate on only when opposite gate sensed off
// - hiccup event: drivers low, discharge soft-start
// - hiccup waits 32768 cycles, then soft-start restart
// - cycle overcurrent holds next high-side turn-on
// - limit program out of window selects internal ref
// - negative limit mirrors positive cycle limit
// - averaged overcurrent over 32 cycles enters hiccup
// - undervoltage 32 cycles: discharge, drivers off
// - undervoltage restart at once when cleared
// - feedback overvoltage over 32 cycles is fault
// - high-side sense overvoltage is hiccup event
// - external overvoltage input above 2V is fault
// - thermal trip starts hiccup protection
// - thermal restart needs cooling and 32768 cycles
// - faults masked until soft-start above 1V
//
// Chosen here: the plain strobed port and the placing of the registers.
`include "bfh_defs.vh"

module bfh_top #(
  parameter [15:0] HICCUP_CYCLES = `BFH_HICCUP_CYCLES
) (
  input wire core_clk,
  input wire nrst,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_q,
  output reg irq_q,
  input wire overcurrent_guard_cycle,
  input wire overcurrent_guard_negative,
  input wire current_monitor_over,
  input wire feedback_node_below_ss,
  input wire feedback_node_above_ss,
  input wire highside_sense_over,
  input wire overvoltage_input_over,
  input wire thermal_trip_hot,
  input wire thermal_trip_cooled,
  input wire ss_above_1v,
  input wire ss_above_50mv,
  input wire limit_program_in_window,
  input wire high_side_gate_off,
  input wire low_side_gate_off,
  input wire pwm_high_request,
  input wire phase_share_config_done,
  output reg high_side_gate_q,
  output reg low_side_gate_q,
  output reg sense_cascode_gate_q,
  output reg ss_discharge_q,
  output reg limit_internal_ref_q,
  output reg phase_share_link_active_q,
  output reg current_share_regulate_q
);

  localparam [15:0] HC_LAST = HICCUP_CYCLES - 16'h0001;

  // two-stage synchronisers
  wire [`BFH_IN_W-1:0] raw_in;
  reg [`BFH_IN_W-1:0] sync1_q;
  reg [`BFH_IN_W-1:0] sync2_q;

  assign raw_in = {phase_share_config_done, pwm_high_request,
                   low_side_gate_off, high_side_gate_off,
                   limit_program_in_window, ss_above_50mv, ss_above_1v,
                   thermal_trip_cooled, thermal_trip_hot,
                   overvoltage_input_over, highside_sense_over,
                   feedback_node_above_ss, feedback_node_below_ss,
                   current_monitor_over, overcurrent_guard_negative,
                   overcurrent_guard_cycle};

  genvar gi;
  generate
    for (gi = 0; gi < `BFH_IN_W; gi = gi + 1) begin : g_sync
      always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire ocp_cyc = sync2_q[`BFH_IN_OCP_CYC];
  wire ocp_neg = sync2_q[`BFH_IN_OCP_NEG];
  wire csh_ov = sync2_q[`BFH_IN_CSH_OV];
  wire ext_ov = sync2_q[`BFH_IN_EXT_OV];
  wire therm_hot = sync2_q[`BFH_IN_THERM_HOT];
  wire therm_cool = sync2_q[`BFH_IN_THERM_COOL];
  wire ss_1v = sync2_q[`BFH_IN_SS_1V];
  wire ss_50mv = sync2_q[`BFH_IN_SS_50MV];
  wire limit_program_input_win = sync2_q[`BFH_IN_LIMIT_PROGRAM_INPUT_WIN];
  wire hs_off = sync2_q[`BFH_IN_HS_OFF];
  wire ls_off = sync2_q[`BFH_IN_LS_OFF];
  wire pwm_hs = sync2_q[`BFH_IN_PWM_HS];
  wire cfg_done = sync2_q[`BFH_IN_CFG_DONE];

  // software registers, sequencer state and counter, high-side hold
  reg [1:0] ctrl_q;
  reg [`BFH_EV_W-1:0] int_stat_q;
  reg [`BFH_EV_W-1:0] int_mask_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [15:0] hic_cnt_q;
  reg [15:0] hic_cnt_d;
  reg hs_hold_q;

  // protection enabled only once soft-start passes 1V
  wire prot_en = ss_1v;

  // qualification counters: average oc, undervoltage, feedback ov
  wire [2:0] qual_flag;
  wire [17:0] qual_thr;
  reg [17:0] qual_cnt_q;
  wire [2:0] qual_hit;

  assign qual_flag = {sync2_q[`BFH_IN_FB_ABOVE],
                      sync2_q[`BFH_IN_FB_BELOW],
                      sync2_q[`BFH_IN_CURRENT_MONITOR_OUTPUT_OVER]};
  assign qual_thr = {`BFH_QUAL_MORE_32,
                     `BFH_QUAL_LEAST_32,
                     `BFH_QUAL_MORE_32};

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_qual
      always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          qual_cnt_q[gi*6 +: 6] <= 6'h00;
        end else if (!qual_flag[gi] || !prot_en) begin
          qual_cnt_q[gi*6 +: 6] <= 6'h00;
        end else if (qual_cnt_q[gi*6 +: 6] != qual_thr[gi*6 +: 6]) begin
          qual_cnt_q[gi*6 +: 6] <= qual_cnt_q[gi*6 +: 6] + 6'h01;
        end
      end
      assign qual_hit[gi] = qual_cnt_q[gi*6 +: 6] == qual_thr[gi*6 +: 6];
    end
  endgenerate

  wire avg_oc = qual_hit[0];
  wire uv_flt = qual_hit[1];
  wire fb_ov = qual_hit[2];
  wire csh_flt = csh_ov & prot_en;
  wire ext_flt = ext_ov & prot_en;
  wire therm_flt = therm_hot & prot_en;
  wire hiccup_ev = avg_oc | csh_flt | fb_ov;

  wire hic_done = hic_cnt_q == HC_LAST;

  // sequencer
  always @* begin
    state_d = state_q;
    hic_cnt_d = hic_cnt_q;
    case (state_q)
      `BFH_ST_INIT: begin
        hic_cnt_d = 16'h0000;
        if (ctrl_q[`BFH_CTRL_ENABLE] && cfg_done) begin
          state_d = `BFH_ST_RUN;
        end
      end
      `BFH_ST_RUN: begin
        hic_cnt_d = 16'h0000;
        if (!ctrl_q[`BFH_CTRL_ENABLE]) begin
          state_d = `BFH_ST_INIT;
        end else if (therm_flt) begin
          state_d = `BFH_ST_THERM;
        end else if (hiccup_ev) begin
          state_d = `BFH_ST_HICCUP;
        end else if (uv_flt) begin
          state_d = `BFH_ST_UV_WAIT;
        end else if (ext_flt) begin
          state_d = `BFH_ST_EXT_OV;
        end
      end
      `BFH_ST_HICCUP: begin
        if (hic_done) begin
          state_d = `BFH_ST_RUN;
        end else begin
          hic_cnt_d = hic_cnt_q + 16'h0001;
        end
      end
      `BFH_ST_UV_WAIT: begin
        if (!sync2_q[`BFH_IN_FB_BELOW]) begin
          state_d = `BFH_ST_RUN;
        end
      end
      `BFH_ST_THERM: begin
        if (!hic_done) begin
          hic_cnt_d = hic_cnt_q + 16'h0001;
        end else if (therm_cool) begin
          state_d = `BFH_ST_RUN;
        end
      end
      `BFH_ST_EXT_OV: begin
        if (!ext_ov) begin
          state_d = `BFH_ST_RUN;
        end
      end
      default: begin
        state_d = `BFH_ST_INIT;
      end
    endcase
    if (!ctrl_q[`BFH_CTRL_ENABLE]) begin
      state_d = `BFH_ST_INIT;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= `BFH_ST_INIT;
      hic_cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      hic_cnt_q <= hic_cnt_d;
    end
  end

  // drivers only while running, leaving state forces them low
  wire drive_en = (state_d == `BFH_ST_RUN) && ss_50mv;

  // high-side hold set while low side on and cycle limit exceeded, kept until the limit clears
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hs_hold_q <= 1'b0;
    end else if (low_side_gate_q && ocp_cyc) begin
      hs_hold_q <= 1'b1;
    end else if (!ocp_cyc) begin
      hs_hold_q <= 1'b0;
    end
  end

  // commands one cycle back: the synced sense lags a gate just driven
  reg ls_was_q;
  reg hs_was_q;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ls_was_q <= 1'b0;
      hs_was_q <= 1'b0;
    end else begin
      ls_was_q <= low_side_gate_q;
      hs_was_q <= high_side_gate_q;
    end
  end

  wire hs_go = drive_en && pwm_hs && ls_off && !low_side_gate_q
               && !ls_was_q
               && !hs_hold_q && !(low_side_gate_q && ocp_cyc);
  wire ls_go = drive_en && !pwm_hs && hs_off && !high_side_gate_q
               && !hs_was_q
               && !ocp_neg;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      high_side_gate_q <= 1'b0;
      low_side_gate_q <= 1'b0;
      sense_cascode_gate_q <= 1'b0;
      ss_discharge_q <= 1'b1;
    end else begin
      high_side_gate_q <= hs_go;
      low_side_gate_q <= ls_go;
      sense_cascode_gate_q <= ls_go;
      ss_discharge_q <= state_d != `BFH_ST_RUN;
    end
  end

  // limit reference selection shared by both polarities
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      limit_internal_ref_q <= 1'b1;
    end else begin
      limit_internal_ref_q <= !limit_program_input_win;
    end
  end

  // current sharing over the phase link
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_share_link_active_q <= 1'b0;
      current_share_regulate_q <= 1'b0;
    end else begin
      phase_share_link_active_q <= cfg_done;
      current_share_regulate_q <= cfg_done && ctrl_q[`BFH_CTRL_SLAVE]
                                  && state_d == `BFH_ST_RUN;
    end
  end

  // events into sticky status
  wire [`BFH_EV_W-1:0] ev_set;
  assign ev_set = {ocp_cyc & low_side_gate_q, ext_flt, fb_ov, uv_flt,
                   therm_flt, csh_flt, avg_oc};

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `BFH_CTRL_RESET;
      int_mask_q <= `BFH_MASK_RESET;
      int_stat_q <= {`BFH_EV_W{1'b0}};
    end else begin
      if (reg_wr && reg_addr == `BFH_ADDR_CTRL) begin
        ctrl_q <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == `BFH_ADDR_INT_MASK) begin
        int_mask_q <= reg_wdata[`BFH_EV_W-1:0];
      end
      if (reg_wr && reg_addr == `BFH_ADDR_INT_STAT) begin
        int_stat_q <= (int_stat_q & ~reg_wdata[`BFH_EV_W-1:0]) | ev_set;
      end else begin
        int_stat_q <= int_stat_q | ev_set;
      end
    end
  end

  // read data one cycle after the strobe, interrupt level
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_stat_q & int_mask_q);
      if (reg_rd) begin
        case (reg_addr)
          `BFH_ADDR_CTRL: reg_rdata_q <= {14'h0000, ctrl_q};
          `BFH_ADDR_STATUS: reg_rdata_q <= {5'h00, ocp_cyc, ext_ov,
                                            therm_hot, csh_ov, uv_flt,
                                            fb_ov, avg_oc, limit_internal_ref_q,
                                            state_q};
          `BFH_ADDR_INT_STAT: reg_rdata_q <= {9'h000, int_stat_q};
          `BFH_ADDR_INT_MASK: reg_rdata_q <= {9'h000, int_mask_q};
          `BFH_ADDR_HICCUP_CNT: reg_rdata_q <= hic_cnt_q;
          default: reg_rdata_q <= 16'h0000;
        endcase
      end else begin
        reg_rdata_q <= 16'h0000;
      end
    end
  end

endmodule // bfh_top

// ---- tb/bfh_asserts.sv ----
// bfh_asserts.sv: port checks of the fault and gate sequencer
// assumes bind onto bfh_top; an input reaches an output three edges on
module bfh_asserts (
  input wire core_clk,
  input wire nrst,
  input wire overcurrent_guard_cycle,
  input wire limit_program_in_window,
  input wire high_side_gate_off,
  input wire low_side_gate_off,
  input wire phase_share_config_done,
  input wire high_side_gate_q,
  input wire low_side_gate_q,
  input wire sense_cascode_gate_q,
  input wire ss_discharge_q,
  input wire limit_internal_ref_q,
  input wire phase_share_link_active_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_q;
  wire up = (up_q == 2'h3);
  // keeps $past away from values seen before reset released
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_no_overlap: assert property (!(high_side_gate_q && low_side_gate_q))
    else $error("both gates on");
  a_high_waits: assert property ($rose(high_side_gate_q) |->
    up && $past(low_side_gate_off, 3) && !$past(low_side_gate_q)
    && !$past(low_side_gate_q, 2))
    else $error("high gate on before low gate off");
  a_low_waits: assert property ($rose(low_side_gate_q) |->
    up && $past(high_side_gate_off, 3) && !$past(high_side_gate_q)
    && !$past(high_side_gate_q, 2))
    else $error("low gate on before high gate off");
  a_cascode_low: assert property (sense_cascode_gate_q == low_side_gate_q)
    else $error("cascode gate differs from low gate");
  a_drivers_blank: assert property (ss_discharge_q |->
    !high_side_gate_q && !low_side_gate_q)
    else $error("gate on while discharging");
  a_oc_holds: assert property ($rose(high_side_gate_q) |->
    !$past(overcurrent_guard_cycle, 3))
    else $error("high gate on during overcurrent");
  a_ref_window: assert property (up |->
    limit_internal_ref_q == !$past(limit_program_in_window, 3))
    else $error("limit reference choice wrong");
  a_link_cfg: assert property (up |->
    phase_share_link_active_q == $past(phase_share_config_done, 3))
    else $error("share link does not follow config");
endmodule // bfh_asserts

bind bfh_top bfh_asserts u_chk (.core_clk, .nrst, .overcurrent_guard_cycle,
  .limit_program_in_window, .high_side_gate_off, .low_side_gate_off,
  .phase_share_config_done, .high_side_gate_q, .low_side_gate_q,
  .sense_cascode_gate_q, .ss_discharge_q, .limit_internal_ref_q,
  .phase_share_link_active_q);

// ---- tb/bfh_fet_model.sv ----
// bfh_fet_model.sv: switch pair whose gates take time to discharge
// assumes gate commands from bfh_top; off senses go back to it
module bfh_fet_model (
  input wire core_clk,
  input wire high_gate,
  input wire low_gate,
  output wire high_off,
  output wire low_off
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hi_q = 2'h0;
  logic [1:0] lo_q = 2'h0;
  // a gate reads off only two cycles after its command drops
  always @(posedge core_clk) begin
    hi_q <= {hi_q[0], high_gate};
    lo_q <= {lo_q[0], low_gate};
  end
  assign high_off = !(high_gate || hi_q != 2'h0);
  assign low_off = !(low_gate || lo_q != 2'h0);
endmodule // bfh_fet_model

// ---- tb/tb_bfh_top.sv ----
// tb_bfh_top.sv: directed tests of the fault and gate sequencer
// assumes bfh_top, bfh_fet_model and the bound checker are compiled
`include "bfh_defs.vh"
module tb_bfh_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HC = 16;
  logic core_clk = 0;
  logic nrst = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 0;
  logic rd_s = 0;
  logic [5:0] flt = 6'h00;
  logic cyc_oc = 0;
  logic cooled = 0;
  logic ss_1v = 1;
  logic win = 1;
  logic pwm = 1;
  logic cfg = 0;
  logic neg_oc = 0;
  wire [15:0] rdata;
  wire irq, hs, ls, csg, dis, iref, link, share, hs_off, ls_off;
  logic [15:0] d;
  int n;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int qb[2] = '{0, 4};
  always #10 core_clk = ~core_clk;
  bfh_top #(.HICCUP_CYCLES(16'h0010)) uut (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata_q(rdata), .irq_q(irq), .overcurrent_guard_cycle(cyc_oc),
    .overcurrent_guard_negative(neg_oc), .current_monitor_over(flt[0]),
    .highside_sense_over(flt[1]), .thermal_trip_hot(flt[2]),
    .feedback_node_below_ss(flt[3]), .feedback_node_above_ss(flt[4]),
    .overvoltage_input_over(flt[5]), .thermal_trip_cooled(cooled),
    .ss_above_1v(ss_1v), .ss_above_50mv(1'b1),
    .limit_program_in_window(win), .high_side_gate_off(hs_off),
    .low_side_gate_off(ls_off), .pwm_high_request(pwm),
    .phase_share_config_done(cfg), .high_side_gate_q(hs),
    .low_side_gate_q(ls), .sense_cascode_gate_q(csg), .ss_discharge_q(dis),
    .limit_internal_ref_q(iref), .phase_share_link_active_q(link),
    .current_share_regulate_q(share));
  bfh_fet_model u_fet (.core_clk(core_clk), .high_gate(hs), .low_gate(ls),
    .high_off(hs_off), .low_off(ls_off));
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    wr_s <= 1;
    addr <= a;
    wdata <= v;
    @(posedge core_clk);
    wr_s <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    rd_s <= 1;
    addr <= a;
    @(posedge core_clk);
    rd_s <= 0;
    #1 v = rdata;
  endtask
  task automatic hold_flt(input int b, input int len);
    @(posedge core_clk) flt[b] <= 1;
    tick(len);
    flt[b] <= 0;
  endtask
  task automatic wait_dis(input logic want);
    n = 0;
    // look only once the launching edge has settled
    #1;
    while (dis !== want && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    tick(3);
    chk("discharge_rst", 1, dis);
    chk("gates_rst", 0, {hs, ls});
    nrst <= 1;
    cfg <= 1;
    rd(`BFH_ADDR_CTRL, d);
    chk("ctrl_rst", 0, d);
    wr(`BFH_ADDR_CTRL, 16'h0003);
    rd(4'hf, d);
    chk("unmapped", 0, d);
    tick(10);
    rd(`BFH_ADDR_STATUS, d);
    chk("state_run", 1, d & 16'h0007);
    chk("link_share", 3, {link, share});
    chk("high_on", 1, hs);
    @(posedge core_clk) win <= 0;
    tick(5);
    #1 chk("int_ref", 1, iref);
    @(posedge core_clk) pwm <= 0;
    win <= 1;
    tick(10);
    #1 chk("low_on", 1, ls);
    @(posedge core_clk) cyc_oc <= 1;
    tick(4);
    pwm <= 1;
    tick(12);
    #1 chk("high_held", 0, hs);
    rd(`BFH_ADDR_INT_STAT, d);
    chk("int_cyc_oc", 16'h0040, d);
    @(posedge core_clk) cyc_oc <= 0;
    tick(12);
    #1 chk("high_resumed", 1, hs);
    wr(`BFH_ADDR_INT_STAT, 16'h0040);
    wr(`BFH_ADDR_INT_MASK, 16'h0002);
    hold_flt(1, 3);
    wait_dis(1);
    wait_dis(0);
    chk("hiccup_len", 1, n >= HC && n <= HC + 2);
    rd(`BFH_ADDR_INT_STAT, d);
    chk("int_csh", 16'h0002, d);
    chk("irq_on", 1, irq);
    wr(`BFH_ADDR_INT_MASK, 16'h0000);
    tick(2);
    #1 chk("irq_masked", 0, irq);
    wr(`BFH_ADDR_INT_MASK, 16'h0002);
    wr(`BFH_ADDR_INT_STAT, 16'h0002);
    tick(2);
    #1 chk("irq_cleared", 0, irq);
    foreach (qb[i]) begin
      hold_flt(qb[i], 32);
      hold_flt(qb[i], 32);
      tick(4);
      #1 chk("qual_32", 0, dis);
      hold_flt(qb[i], 40);
      wait_dis(1);
      chk("qual_trip", 1, dis);
      wait_dis(0);
      tick(8);
    end
    hold_flt(3, 31);
    tick(4);
    #1 chk("uv_31", 0, dis);
    @(posedge core_clk) flt[3] <= 1;
    wait_dis(1);
    tick(6);
    #1 chk("uv_held", 1, dis);
    @(posedge core_clk) flt[3] <= 0;
    wait_dis(0);
    chk("uv_quick", 1, n < HC - 8);
    @(posedge core_clk) flt[5] <= 1;
    wait_dis(1);
    chk("ext_ov_trip", 1, n <= 4);
    @(posedge core_clk) flt[5] <= 0;
    wait_dis(0);
    chk("ext_ov_clear", 1, n <= 8);
    hold_flt(2, 6);
    wait_dis(1);
    tick(HC + 8);
    #1 chk("therm_wait", 1, dis);
    @(posedge core_clk) cooled <= 1;
    wait_dis(0);
    chk("therm_restart", 1, n <= 6);
    hold_flt(2, 3);
    wait_dis(1);
    wait_dis(0);
    chk("therm_min", 1, n >= HC);
    @(posedge core_clk) ss_1v <= 0;
    hold_flt(1, 8);
    tick(4);
    #1 chk("masked_ss", 0, dis);
    @(posedge core_clk) pwm <= 0;
    neg_oc <= 1;
    tick(12);
    #1 chk("neg_oc_low", 0, ls);
    @(posedge core_clk) neg_oc <= 0;
    tick(12);
    #1 chk("neg_oc_free", 1, ls);
    end_of_test();
  end
endmodule // tb_bfh_top
